/* File: bench/ctsup_asserts.sv */
// Purpose: port checker for the wiring supervision top
// Assumes: one clock, synchronous active low reset
// Notes:   windows follow the tick, eval and event latencies
`timescale 1ns/100ps
`default_nettype none
module ctsup_asserts
(
   input wire logic        CORE_CLK_IN,
   input wire logic        NRST_IN,
   input wire logic        CYCLE_TICK_IN,
   input wire logic        BLOCK_IN,
   input wire logic [47:0] TIMESTAMP_IN,
   input wire logic        EVENT_ON_SEL_IN,
   input wire logic        EVENT_OFF_SEL_IN,
   input wire logic        START_OUT,
   input wire logic        ALARM_OUT,
   input wire logic        BLOCKED_OUT,
   input wire logic [4:0]  FAULT_STATUS_OUT,
   input wire logic        EVENT_VALID_OUT,
   input wire logic        EVENT_STORE_OUT,
   input wire logic [1:0]  EVENT_CODE_OUT,
   input wire logic [47:0] EVENT_STAMP_OUT,
   input wire logic [3:0]  LOG_COUNT_OUT
);
   default clocking dc @(posedge CORE_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   // start only when every condition bit of the last tick holds
   AST_START_ALL: assert property ($rose(START_OUT)
      |-> FAULT_STATUS_OUT == 5'h1F) else $error("start without all conditions");
   // a lost condition drops start and alarm at the next evaluation
   AST_DROP: assert property ($changed(FAULT_STATUS_OUT)
      && FAULT_STATUS_OUT != 5'h1F |=> !START_OUT && !ALARM_OUT)
      else $error("state kept after condition loss");
   AST_ALARM_AFTER_START: assert property ($rose(ALARM_OUT) |-> $past(START_OUT))
      else $error("alarm without running delay");
   AST_ALARM_EVENT: assert property ($rose(ALARM_OUT)
      |=> EVENT_VALID_OUT && EVENT_CODE_OUT == 2'h0) else $error("no alarm on event");
   AST_STAMP: assert property (EVENT_VALID_OUT |-> EVENT_STAMP_OUT == $past(TIMESTAMP_IN))
      else $error("event stamp wrong");
   AST_STORE: assert property (EVENT_STORE_OUT == (EVENT_VALID_OUT && (EVENT_CODE_OUT[0] ?
      $past(EVENT_OFF_SEL_IN) : $past(EVENT_ON_SEL_IN)))) else $error("store select wrong");
   AST_BLOCK_TICK: assert property ($rose(BLOCKED_OUT)
      |-> $past(BLOCK_IN, 2) && $past(CYCLE_TICK_IN, 2)) else $error("block not from tick");
   AST_LOG_CAP: assert property (LOG_COUNT_OUT <= 4'hC)
      else $error("log count above depth");
endmodule
bind ctsup_top ctsup_asserts u_asserts
(
   .CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN), .CYCLE_TICK_IN(CYCLE_TICK_IN),
   .BLOCK_IN(BLOCK_IN), .TIMESTAMP_IN(TIMESTAMP_IN), .EVENT_ON_SEL_IN(EVENT_ON_SEL_IN),
   .EVENT_OFF_SEL_IN(EVENT_OFF_SEL_IN), .START_OUT(START_OUT), .ALARM_OUT(ALARM_OUT),
   .BLOCKED_OUT(BLOCKED_OUT), .FAULT_STATUS_OUT(FAULT_STATUS_OUT),
   .EVENT_VALID_OUT(EVENT_VALID_OUT), .EVENT_STORE_OUT(EVENT_STORE_OUT),
   .EVENT_CODE_OUT(EVENT_CODE_OUT), .EVENT_STAMP_OUT(EVENT_STAMP_OUT),
   .LOG_COUNT_OUT(LOG_COUNT_OUT)
);
`default_nettype wire

/* File: bench/ctsup_meas_model.sv */
// Purpose: phase and residual measurement channel model
// Assumes: mode picks one steady measurement case
// Notes:   packed msb first as isum, i01, i2, i1, il3, il2, il1
`timescale 1ns/100ps
`default_nettype none
module ctsup_meas_model
(
   input  wire logic [2:0]   mode_in,
   output logic      [111:0] cur_out
);
   // fixed cases keep expectations exact; a lost phase reads zero, except 5 in mode 2
   always_comb
   begin
      case (mode_in)
         3'h1: cur_out = {16'h0064, 16'h0000, 16'h0021, 16'h0043, 16'h0064, 16'h0064, 16'h0000};
         3'h2: cur_out = {16'h0064, 16'h0000, 16'h002B, 16'h0055, 16'h0064, 16'h0096, 16'h0005};
         3'h3: cur_out = {16'h0064, 16'h0000, 16'h0002, 16'h0003, 16'h0005, 16'h0005, 16'h0000};
         3'h4: cur_out = {16'h0064, 16'h0064, 16'h0021, 16'h0043, 16'h0064, 16'h0064, 16'h0000};
         default: cur_out = {16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064, 16'h0064, 16'h0064};
      endcase
   end
endmodule
`default_nettype wire

/* File: bench/ctsup_tb_top.sv */
// Purpose: self-checking bench for the wiring supervision
// Assumes: four clocks per ms and per program cycle
// Notes:   limits at recommended values, alarm delay 3 ms
`timescale 1ns/100ps
`default_nettype none
module ctsup_tb_top;
   localparam int MSC = 4;
   logic          clk, rst_n, tick, blk, res, on_s, off_s, clr, lv;
   logic [2:0]    mode, grp, m;
   logic [3:0]    rd_idx, lcnt;
   logic [4:0]    flt;
   logic [15:0]   lfsr = 16'h85BF, ecnt;
   logic [20:0]   dly, tta;
   logic [47:0]   ts;
   logic [111:0]  cur;
   logic [190:0]  rdat;
   logic          st, al, bl;
   int            num_errors, comparisons, cyc;

   ctsup_meas_model u_meas (.mode_in(mode), .cur_out(cur));
   ctsup_top #(.MS_CYCLES(MSC)) DUT
   (
      .CORE_CLK_IN(clk), .NRST_IN(rst_n), .CYCLE_TICK_IN(tick), .BLOCK_IN(blk),
      .IL1_IN(cur[15:0]), .IL2_IN(cur[31:16]), .IL3_IN(cur[47:32]), .I1_IN(cur[63:48]),
      .I2_IN(cur[79:64]), .ISUM_IN(cur[111:96]), .I01_IN(cur[95:80]), .I02_IN(cur[95:80]),
      .HIGH_LIMIT_IN(ctsup_pkg::HIGH_LIMIT_DEF), .LOW_LIMIT_IN(ctsup_pkg::LOW_LIMIT_DEF),
      .RATIO_LIMIT_IN(ctsup_pkg::RATIO_DEF), .SEQUENCE_RATIO_THRESHOLD_IN(ctsup_pkg::SEQ_RATIO_DEF),
      .SUM_DIFF_LIMIT_IN(ctsup_pkg::SUM_DIFF_DEF), .RESIDUAL_INPUT_SELECT_IN(res),
      .ALARM_DELAY_MS_IN(dly), .TIMESTAMP_IN(ts), .SETTING_GROUP_IN(grp), .EVENT_ON_SEL_IN(on_s),
      .EVENT_OFF_SEL_IN(off_s), .COUNTER_CLEAR_IN(clr), .LOG_RD_INDEX_IN(rd_idx),
      .START_OUT(st), .ALARM_OUT(al), .BLOCKED_OUT(bl), .FAULT_STATUS_OUT(flt),
      .TIME_TO_ALARM_OUT(tta), .EVENT_VALID_OUT(), .EVENT_STORE_OUT(), .EVENT_CODE_OUT(),
      .EVENT_STAMP_OUT(), .EVENT_COUNT_OUT(ecnt), .LOG_COUNT_OUT(lcnt),
      .LOG_RD_VALID_OUT(lv), .LOG_RD_DATA_OUT(rdat)
   );

   function automatic logic [15:0] nxt_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // condition bits per measurement case; residual bit is forced high when unselected
   function automatic logic [4:0] exp_flt(input logic [2:0] c, input logic r);
      logic [3:0] b;
      case (c)
         3'h0: b = 4'h3;
         3'h2: b = 4'hE;
         3'h3: b = 4'hD;
         default: b = 4'hF;
      endcase
      return {!r || (c != 3'h0 && c != 3'h4), b};
   endfunction

   task automatic check_val(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // hold one case for n clocks; ends just after an edge so outputs have settled
   task automatic run(input logic [2:0] c, input logic r, input logic b, input int n);
      @(posedge clk);
      mode <= c;
      res <= r;
      blk <= b;
      repeat (n) @(posedge clk);
      #1;
   endtask

   // free running 125 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // random stamp, group and store selections; program tick every fourth clock
   always @(posedge clk)
   begin
      lfsr <= nxt_rand(lfsr);
      ts <= {lfsr, ~lfsr, lfsr};
      grp <= lfsr[2:0];
      on_s <= lfsr[3];
      off_s <= lfsr[4];
      tick <= rst_n && (cyc % 4 == 3);
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         num_errors++;
         print_verdict();
      end
   end

   // main sequence: quiet cases, then pickup, alarm, block, residual and log fill
   initial
   begin
      {rst_n, blk, res, clr, mode, rd_idx} = '0;
      dly = 21'h000003;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         m = (k == 0) ? 3'h0 : 3'(k + 1);
         run(m, k == 3, 1'b0, 12);
         check_val(flt, exp_flt(m, k == 3));
         check_val(st, 1'b0);
      end
      run(3'h1, 1'b0, 1'b0, 10);
      check_val(flt, exp_flt(3'h1, 1'b0));
      check_val({st, al}, 2'h2);
      run(3'h0, 1'b0, 1'b0, 8);
      check_val(st, 1'b0);
      check_val(tta, dly);
      run(3'h1, 1'b0, 1'b0, 30);
      check_val(al, 1'b1);
      run(3'h1, 1'b0, 1'b1, 10);
      check_val({bl, al}, 2'h2);
      run(3'h0, 1'b0, 1'b0, 10);
      run(3'h1, 1'b1, 1'b0, 30);
      check_val(al, 1'b1);
      check_val({lv, rdat[187:162], rdat[49:48], rdat[65:50]},
                {1'b1, 26'h3E00000, 2'h0, 16'h0000});
      check_val(ecnt, 16'h0003);
      run(3'h0, 1'b0, 1'b0, 10);
      run(3'h4, 1'b0, 1'b0, 30);
      check_val(al, 1'b1);
      clr <= 1'b1;
      run(3'h4, 1'b0, 1'b0, 2);
      clr <= 1'b0;
      check_val(ecnt, 16'h0000);
      for (int k = 0; k < 20; k++)
         run(3'h1, 1'b0, !k[0], 10);
      check_val(lcnt, 4'hC);
      check_val(ecnt, 16'h000A);
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: hw/ctsup_delay_timer.sv */
// Purpose: definite time delay in milliseconds for the alarm
// Assumes: run_in is a level from the same clock domain
// Notes:   counter clears whenever run_in drops
`timescale 1ns/100ps
`default_nettype none
module ctsup_delay_timer
#(
   parameter int MS_CYCLES = ctsup_pkg::CYCLES_PER_MS,
   parameter int DLY_W     = ctsup_pkg::DLY_W
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             run_in,
   input  wire logic [DLY_W-1:0] delay_ms_in,
   output logic                  expired_out,
   output logic      [DLY_W-1:0] remain_ms_out
);
   localparam int DIV_W = $clog2(MS_CYCLES + 1);

   logic [DIV_W-1:0] div_ff;
   logic [DLY_W-1:0] elapsed_ff;
   logic             ms_tick;

   // divider restarts with each run so the first millisecond is a whole one
   assign ms_tick = run_in && (div_ff == DIV_W'(MS_CYCLES - 1));
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in || !run_in || ms_tick)
         div_ff <= '0;
      else
         div_ff <= div_ff + 1'b1;
   end

   // elapsed stops at the delay, so it cannot wrap during long faults
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in || !run_in)
         elapsed_ff <= '0;
      else if (ms_tick && !expired_out)
         elapsed_ff <= elapsed_ff + 1'b1;
   end

   assign expired_out   = run_in && (elapsed_ff >= delay_ms_in);
   assign remain_ms_out = (elapsed_ff >= delay_ms_in) ? '0 : delay_ms_in - elapsed_ff;
endmodule
`default_nettype wire

/* File: hw/ctsup_log.sv */
// Purpose: ring store of the most recent time-stamped records
// Assumes: at most one write per clock
// Notes:   read index 0 is the newest record, read data lags the index by one clock
`timescale 1ns/100ps
`default_nettype none
module ctsup_log
#(
   parameter int DEPTH = ctsup_pkg::LOG_DEPTH,
   parameter int W     = ctsup_pkg::REC_W,
   parameter int IDX_W = ctsup_pkg::IDX_W
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             wr_in,
   input  wire logic [W-1:0]     wr_data_in,
   input  wire logic [IDX_W-1:0] rd_idx_in,
   output logic      [IDX_W-1:0] count_out,
   output logic                  rd_valid_out,
   output logic      [W-1:0]     rd_data_out
);
   logic [W-1:0]     mem_ff [DEPTH];
   logic [IDX_W-1:0] wr_ptr_ff;
   logic [IDX_W:0]   slot;
   logic             hit;

   // oldest slot is overwritten once the store is full
   always_ff @(posedge clk_in)
   begin
      if (wr_in)
         mem_ff[wr_ptr_ff] <= wr_data_in; // [R11]
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         wr_ptr_ff <= '0;
         count_out <= '0;
      end
      else if (wr_in)
      begin
         wr_ptr_ff <= (wr_ptr_ff == IDX_W'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1; // [R11]
         if (count_out != IDX_W'(DEPTH))
            count_out <= count_out + 1'b1;
      end
   end

   // newest-relative index to physical slot
   always_comb
   begin
      slot = {1'b0, wr_ptr_ff} + (IDX_W+1)'(DEPTH - 1) - {1'b0, rd_idx_in};
      if (slot >= (IDX_W+1)'(DEPTH))
         slot = slot - (IDX_W+1)'(DEPTH);
   end
   assign hit = rd_idx_in < count_out;

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         rd_valid_out <= 1'b0;
         rd_data_out  <= '0;
      end
      else
      begin
         rd_valid_out <= hit;
         rd_data_out  <= hit ? mem_ff[slot[IDX_W-1:0]] : '0;
      end
   end
endmodule
`default_nettype wire

/* File: hw/ctsup_pkg.sv */
// Purpose: shared constants and types for the current transformer wiring supervision
// Assumes: currents are magnitudes in 0.01 x In steps, ratios in 0.01 % steps
// Notes:   record field positions are used by the top; the log store takes only the record width
package ctsup_pkg;
   // data widths
   localparam int CUR_W = 16;
   localparam int PCT_W = 14;
   localparam int DLY_W = 21;
   localparam int CNT_W = 16;
   localparam int TS_W  = 48;
   localparam int GRP_W = 3;
   localparam int FLT_W = 5;
   localparam int LOG_DEPTH = 12;
   localparam int IDX_W = 4;
   localparam int NCUR  = 7;

   // 100.00 % in ratio units
   localparam logic [PCT_W-1:0] PCT_FULL = 14'h2710;

   // recommended setting values: 1.20 In, 0.10 In, 10.00 %, 49.00 %, 0.10 In, 500 ms
   localparam logic [CUR_W-1:0] HIGH_LIMIT_DEF = 16'h0078;
   localparam logic [CUR_W-1:0] LOW_LIMIT_DEF  = 16'h000A;
   localparam logic [PCT_W-1:0] RATIO_DEF      = 14'h03E8;
   localparam logic [PCT_W-1:0] SEQ_RATIO_DEF  = 14'h1324;
   localparam logic [CUR_W-1:0] SUM_DIFF_DEF   = 16'h000A;
   localparam logic [DLY_W-1:0] DELAY_DEF      = 21'h001F4;

   // millisecond time base derived from the core clock
   localparam int MS_NS         = 1000000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // fault status bit positions, a set bit means the condition holds
   localparam int FLT_HIGH  = 0;
   localparam int FLT_LOW   = 1;
   localparam int FLT_RATIO = 2;
   localparam int FLT_SEQ   = 3;
   localparam int FLT_RES   = 4;

   // log record layout
   localparam int REC_TS_LSB  = 0;
   localparam int REC_EV_LSB  = REC_TS_LSB + TS_W;
   localparam int REC_CUR_LSB = REC_EV_LSB + 2;
   localparam int REC_TTA_LSB = REC_CUR_LSB + NCUR * CUR_W;
   localparam int REC_FLT_LSB = REC_TTA_LSB + DLY_W;
   localparam int REC_GRP_LSB = REC_FLT_LSB + FLT_W;
   localparam int REC_W       = REC_GRP_LSB + GRP_W;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_START   = 2'b01,
      ST_ALARM   = 2'b10,
      ST_BLOCKED = 2'b11
   } ctsup_state_t;

   typedef enum logic [1:0] {
      EV_ALARM_ON  = 2'b00,
      EV_ALARM_OFF = 2'b01,
      EV_BLOCK_ON  = 2'b10,
      EV_BLOCK_OFF = 2'b11
   } ctsup_event_t;
endpackage

/* File: hw/ctsup_top.sv */
// Purpose: current transformer wiring supervision with alarm delay, events, counter and log
// Assumes: CYCLE_TICK_IN is a one-clock program cycle pulse from same-domain logic;
//          all current and setting inputs are same-domain and steady around the tick
// Notes:   conditions are sampled on the tick and acted on one clock later
// Contract
// [R01] A detected fault with all enabled conditions met starts the delay, alarm only if it lasts.
// [R02] Any phase above the upper current limit keeps the supervision from activating.
// [R03] All phases below the lower current limit keep the supervision from activating.
// [R04] With residual selection on, the summed phase current is compared with measured residual.
// [R05] With residual selection on, a residual difference below its limit withholds activation.
// [R06] Without residual selection, a lost primary phase alarms just like a wiring break.
// [R07] Every alarm or block status change gives an event, ON changes also a log record.
// [R08] Only the event polarities selected by configuration are stored to the main buffer.
// [R09] Every event carries a time stamp.
// [R10] A cumulative counter of alarm and blocked events can be reset on request.
// [R11] The log keeps the twelve newest time-stamped records, replacing the oldest.
// [R12] A log record is written only on ON events and holds the process data of that moment.
// [R13] A record holds time, event, currents, time to alarm, fault status and setting group.
// [R14] Block is sampled each program cycle; block at pickup gives blocked and resets start.
// [R15] The min to max phase current ratio must be within its threshold to activate.
// [R16] The negative to positive sequence ratio must reach its threshold to activate.
// [R17] The delay timer and pending start clear as soon as any condition stops holding.
`timescale 1ns/100ps
`default_nettype none
module ctsup_top
#(
   parameter int MS_CYCLES = ctsup_pkg::CYCLES_PER_MS
)
(
   input  wire logic                              CORE_CLK_IN,
   input  wire logic                              NRST_IN,
   input  wire logic                              CYCLE_TICK_IN,
   input  wire logic                              BLOCK_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       IL1_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       IL2_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       IL3_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       I1_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       I2_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       ISUM_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       I01_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       I02_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       HIGH_LIMIT_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       LOW_LIMIT_IN,
   input  wire logic [ctsup_pkg::PCT_W-1:0]       RATIO_LIMIT_IN,
   input  wire logic [ctsup_pkg::PCT_W-1:0]       SEQUENCE_RATIO_THRESHOLD_IN,
   input  wire logic [ctsup_pkg::CUR_W-1:0]       SUM_DIFF_LIMIT_IN,
   input  wire logic                              RESIDUAL_INPUT_SELECT_IN,
   input  wire logic [ctsup_pkg::DLY_W-1:0]       ALARM_DELAY_MS_IN,
   input  wire logic [ctsup_pkg::TS_W-1:0]        TIMESTAMP_IN,
   input  wire logic [ctsup_pkg::GRP_W-1:0]       SETTING_GROUP_IN,
   input  wire logic                              EVENT_ON_SEL_IN,
   input  wire logic                              EVENT_OFF_SEL_IN,
   input  wire logic                              COUNTER_CLEAR_IN,
   input  wire logic [ctsup_pkg::IDX_W-1:0]       LOG_RD_INDEX_IN,
   output logic                                   START_OUT,
   output logic                                   ALARM_OUT,
   output logic                                   BLOCKED_OUT,
   output logic      [ctsup_pkg::FLT_W-1:0]       FAULT_STATUS_OUT,
   output logic      [ctsup_pkg::DLY_W-1:0]       TIME_TO_ALARM_OUT,
   output logic                                   EVENT_VALID_OUT,
   output logic                                   EVENT_STORE_OUT,
   output logic      [1:0]                        EVENT_CODE_OUT,
   output logic      [ctsup_pkg::TS_W-1:0]        EVENT_STAMP_OUT,
   output logic      [ctsup_pkg::CNT_W-1:0]       EVENT_COUNT_OUT,
   output logic      [ctsup_pkg::IDX_W-1:0]       LOG_COUNT_OUT,
   output logic                                   LOG_RD_VALID_OUT,
   output logic      [ctsup_pkg::REC_W-1:0]       LOG_RD_DATA_OUT
);
   localparam int CW = ctsup_pkg::CUR_W;

   ctsup_pkg::ctsup_state_t state_ff;
   ctsup_pkg::ctsup_state_t nxt_state;
   ctsup_pkg::ctsup_event_t ev_code;

   logic [CW-1:0]                   smp_cur_ff [ctsup_pkg::NCUR];
   logic [ctsup_pkg::FLT_W-1:0]     cond;
   logic [ctsup_pkg::FLT_W-1:0]     cond_ff;
   logic [ctsup_pkg::GRP_W-1:0]     group_ff;
   logic [ctsup_pkg::DLY_W-1:0]     tta_ff;
   logic [ctsup_pkg::DLY_W-1:0]     remain_ms;
   logic [ctsup_pkg::REC_W-1:0]     rec;
   logic [CW-1:0]                   imax;
   logic [CW-1:0]                   imin;
   logic [31:0]                     ratio_lhs;
   logic [31:0]                     ratio_rhs;
   logic [31:0]                     seq_lhs;
   logic [31:0]                     seq_rhs;
   logic                            block_ff;
   logic                            eval_ff;
   logic                            pickup;
   logic                            expired;
   logic                            rep_alarm_ff;
   logic                            rep_block_ff;
   logic                            ev_fire;
   logic                            ev_is_on;
   logic                            log_wr_ff;

   // largest of three magnitudes
   function automatic logic [CW-1:0] max3(input logic [CW-1:0] a, b, c);
      logic [CW-1:0] m;
      m = (a > b) ? a : b;
      return (m > c) ? m : c;
   endfunction

   // smallest of three magnitudes
   function automatic logic [CW-1:0] min3(input logic [CW-1:0] a, b, c);
      logic [CW-1:0] m;
      m = (a < b) ? a : b;
      return (m < c) ? m : c;
   endfunction

   // ratios are compared by cross-multiplying, which avoids a divider
   assign imax      = max3(IL1_IN, IL2_IN, IL3_IN);
   assign imin      = min3(IL1_IN, IL2_IN, IL3_IN);
   assign ratio_lhs = 32'(imin) * 32'(ctsup_pkg::PCT_FULL);
   assign ratio_rhs = 32'(imax) * 32'(RATIO_LIMIT_IN);
   assign seq_lhs   = 32'(I2_IN) * 32'(ctsup_pkg::PCT_FULL);
   assign seq_rhs   = 32'(I1_IN) * 32'(SEQUENCE_RATIO_THRESHOLD_IN);

   // activation conditions, each bit set while its condition holds
   always_comb
   begin
      cond = '0;
      cond[ctsup_pkg::FLT_HIGH]  = imax <= HIGH_LIMIT_IN; // [R02]
      cond[ctsup_pkg::FLT_LOW]   = imax > LOW_LIMIT_IN; // [R03]
      cond[ctsup_pkg::FLT_RATIO] = ratio_lhs <= ratio_rhs; // [R15]
      cond[ctsup_pkg::FLT_SEQ]   = seq_lhs >= seq_rhs; // [R16]
      // residual bit is forced true when unselected, so a lost primary phase also alarms
      cond[ctsup_pkg::FLT_RES]   = 1'b1; // [R06]
      if (RESIDUAL_INPUT_SELECT_IN)
         cond[ctsup_pkg::FLT_RES] = ((ISUM_IN > I01_IN) ? ISUM_IN - I01_IN
                                                         : I01_IN - ISUM_IN)
                                    >= SUM_DIFF_LIMIT_IN; // [R04] [R05]
   end

   // program cycle sample: block, conditions and process data for the log
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!NRST_IN)
      begin
         block_ff <= 1'b0;
         cond_ff  <= '0;
         group_ff <= '0;
         eval_ff  <= 1'b0;
      end
      else
      begin
         eval_ff <= CYCLE_TICK_IN;
         if (CYCLE_TICK_IN)
         begin
            block_ff <= BLOCK_IN; // [R14]
            cond_ff  <= cond;
            group_ff <= SETTING_GROUP_IN;
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!NRST_IN)
      begin
         for (int i = 0; i < ctsup_pkg::NCUR; i++)
            smp_cur_ff[i] <= '0;
      end
      else if (CYCLE_TICK_IN)
      begin
         smp_cur_ff[0] <= IL1_IN;
         smp_cur_ff[1] <= IL2_IN;
         smp_cur_ff[2] <= IL3_IN;
         smp_cur_ff[3] <= I01_IN;
         smp_cur_ff[4] <= I02_IN;
         smp_cur_ff[5] <= I1_IN;
         smp_cur_ff[6] <= I2_IN;
      end
   end

   assign pickup = &cond_ff; // [R01]

   // supervision state; alarm may rise between ticks, everything else moves on a tick
   always_comb
   begin
      nxt_state = state_ff;
      if (eval_ff)
      begin
         if (!pickup)
            nxt_state = ctsup_pkg::ST_IDLE; // [R17]
         else if (block_ff)
            nxt_state = ctsup_pkg::ST_BLOCKED; // [R14]
         else
         begin
            unique case (state_ff)
               ctsup_pkg::ST_IDLE:    nxt_state = ctsup_pkg::ST_START; // [R01]
               ctsup_pkg::ST_BLOCKED: nxt_state = ctsup_pkg::ST_START;
               ctsup_pkg::ST_START:   nxt_state = ctsup_pkg::ST_START;
               ctsup_pkg::ST_ALARM:   nxt_state = ctsup_pkg::ST_ALARM;
            endcase
         end
      end
      else if (state_ff == ctsup_pkg::ST_START && expired)
         nxt_state = ctsup_pkg::ST_ALARM; // [R01]
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!NRST_IN)
         state_ff <= ctsup_pkg::ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // timer runs only in start; leaving start for any reason clears it
   ctsup_delay_timer #(
      .MS_CYCLES (MS_CYCLES),
      .DLY_W     (ctsup_pkg::DLY_W)
   ) u_timer (
      .clk_in        (CORE_CLK_IN),
      .rst_n_in      (NRST_IN),
      .run_in        (state_ff == ctsup_pkg::ST_START), // [R17]
      .delay_ms_in   (ALARM_DELAY_MS_IN),
      .expired_out   (expired),
      .remain_ms_out (remain_ms)
   );

   // time left before alarm, frozen when start is left for blocked
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!NRST_IN)
         tta_ff <= '0;
      else if (state_ff == ctsup_pkg::ST_START)
         tta_ff <= remain_ms;
      else if (state_ff == ctsup_pkg::ST_IDLE)
         tta_ff <= ALARM_DELAY_MS_IN;
   end

   assign START_OUT         = state_ff == ctsup_pkg::ST_START;
   assign ALARM_OUT         = state_ff == ctsup_pkg::ST_ALARM;
   assign BLOCKED_OUT       = state_ff == ctsup_pkg::ST_BLOCKED;
   assign FAULT_STATUS_OUT  = cond_ff;
   assign TIME_TO_ALARM_OUT = tta_ff;

   // one event per clock; alarm changes go first, a pending block change waits a clock
   always_comb
   begin
      ev_fire = 1'b0;
      ev_code = ctsup_pkg::EV_ALARM_ON;
      if (ALARM_OUT != rep_alarm_ff)
      begin
         ev_fire = 1'b1; // [R07]
         ev_code = ALARM_OUT ? ctsup_pkg::EV_ALARM_ON : ctsup_pkg::EV_ALARM_OFF;
      end
      else if (BLOCKED_OUT != rep_block_ff)
      begin
         ev_fire = 1'b1; // [R07]
         ev_code = BLOCKED_OUT ? ctsup_pkg::EV_BLOCK_ON : ctsup_pkg::EV_BLOCK_OFF;
      end
   end
   assign ev_is_on = (ev_code == ctsup_pkg::EV_ALARM_ON) || (ev_code == ctsup_pkg::EV_BLOCK_ON);

   // reported states track which changes have already produced an event
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!NRST_IN)
      begin
         rep_alarm_ff <= 1'b0;
         rep_block_ff <= 1'b0;
      end
      else if (ev_fire)
      begin
         if (ev_code == ctsup_pkg::EV_ALARM_ON || ev_code == ctsup_pkg::EV_ALARM_OFF)
            rep_alarm_ff <= ALARM_OUT;
         else
            rep_block_ff <= BLOCKED_OUT;
      end
   end

   // event port, store strobe follows the polarity selection
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!NRST_IN)
      begin
         EVENT_VALID_OUT <= 1'b0;
         EVENT_STORE_OUT <= 1'b0;
         EVENT_CODE_OUT  <= 2'h0;
         EVENT_STAMP_OUT <= '0;
      end
      else
      begin
         EVENT_VALID_OUT <= ev_fire;
         EVENT_STORE_OUT <= ev_fire && (ev_is_on ? EVENT_ON_SEL_IN : EVENT_OFF_SEL_IN); // [R08]
         if (ev_fire)
         begin
            EVENT_CODE_OUT  <= ev_code;
            EVENT_STAMP_OUT <= TIMESTAMP_IN; // [R09]
         end
      end
   end

   // cumulative alarm and blocked count; a count in the clearing clock is kept
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!NRST_IN)
         EVENT_COUNT_OUT <= '0;
      else if (ev_fire && ev_is_on)
      begin
         if (COUNTER_CLEAR_IN)
            EVENT_COUNT_OUT <= ctsup_pkg::CNT_W'(1); // [R10]
         else if (EVENT_COUNT_OUT != '1)
            EVENT_COUNT_OUT <= EVENT_COUNT_OUT + 1'b1; // [R10]
      end
      else if (COUNTER_CLEAR_IN)
         EVENT_COUNT_OUT <= '0; // [R10]
   end

   // log record assembled from the program cycle sample and the event of this clock
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!NRST_IN)
      begin
         log_wr_ff <= 1'b0;
         rec       <= '0;
      end
      else
      begin
         log_wr_ff <= ev_fire && ev_is_on; // [R12]
         if (ev_fire && ev_is_on)
         begin
            rec[ctsup_pkg::REC_TS_LSB +: ctsup_pkg::TS_W]  <= TIMESTAMP_IN; // [R13]
            rec[ctsup_pkg::REC_EV_LSB +: 2]                <= ev_code;
            for (int i = 0; i < ctsup_pkg::NCUR; i++)
               rec[ctsup_pkg::REC_CUR_LSB + i*CW +: CW]    <= smp_cur_ff[i];
            rec[ctsup_pkg::REC_TTA_LSB +: ctsup_pkg::DLY_W] <= tta_ff;
            rec[ctsup_pkg::REC_FLT_LSB +: ctsup_pkg::FLT_W] <= cond_ff;
            rec[ctsup_pkg::REC_GRP_LSB +: ctsup_pkg::GRP_W] <= group_ff;
         end
      end
   end

   ctsup_log #(
      .DEPTH (ctsup_pkg::LOG_DEPTH),
      .W     (ctsup_pkg::REC_W),
      .IDX_W (ctsup_pkg::IDX_W)
   ) u_log (
      .clk_in       (CORE_CLK_IN),
      .rst_n_in     (NRST_IN),
      .wr_in        (log_wr_ff), // [R11]
      .wr_data_in   (rec),
      .rd_idx_in    (LOG_RD_INDEX_IN),
      .count_out    (LOG_COUNT_OUT),
      .rd_valid_out (LOG_RD_VALID_OUT),
      .rd_data_out  (LOG_RD_DATA_OUT)
   );
endmodule
`default_nettype wire
